/* File: include/urs_pkg.sv */
// offsets, field positions, reset values and pin carriers of the reset-state register bank
package urs_pkg;

    // offsets, normal bank
    localparam logic [2:0] URS_OFS_HOLD  = 3'h0;
    localparam logic [2:0] URS_OFS_IEN   = 3'h1;
    localparam logic [2:0] URS_OFS_IST   = 3'h2;
    localparam logic [2:0] URS_OFS_LCTL  = 3'h3;
    localparam logic [2:0] URS_OFS_MCTL  = 3'h4;
    localparam logic [2:0] URS_OFS_LSTS  = 3'h5;
    localparam logic [2:0] URS_OFS_MSTS  = 3'h6;
    localparam logic [2:0] URS_OFS_SCR   = 3'h7;
    // offsets, divisor bank (line control bit 7 set)
    localparam logic [2:0] URS_OFS_DIVL  = 3'h0;
    localparam logic [2:0] URS_OFS_DIVH  = 3'h1;
    localparam logic [2:0] URS_OFS_FRAC  = 3'h2;
    // offsets, enhanced bank (line control equals the key)
    localparam logic [2:0] URS_OFS_TRIG  = 3'h0;
    localparam logic [2:0] URS_OFS_FEAT  = 3'h1;
    localparam logic [2:0] URS_OFS_EFEAT = 3'h2;
    localparam logic [2:0] URS_OFS_RES1  = 3'h4;
    localparam logic [2:0] URS_OFS_RES2  = 3'h5;
    localparam logic [2:0] URS_OFS_PAU1  = 3'h6;
    localparam logic [2:0] URS_OFS_PAU2  = 3'h7;
    localparam logic [7:0] URS_LCTL_ENH_KEY = 8'hbf;

    // field positions
    localparam int URS_LCTL_DLAB  = 7;
    localparam int URS_LCTL_BREAK = 6;
    localparam int URS_MCTL_DTR   = 0;
    localparam int URS_MCTL_RTS   = 1;
    localparam int URS_MCTL_OUT2  = 3;
    localparam int URS_IEN_MODEM  = 3;
    localparam int URS_FEAT_SWAP  = 6;
    localparam int URS_EFEAT_ENH  = 4;
    // enhanced-only bits, frozen while the enhanced enable is clear
    localparam logic [7:0] URS_IEN_ENH_MASK  = 8'hf0;
    localparam logic [7:0] URS_FCTL_ENH_MASK = 8'h38;
    localparam logic [7:0] URS_MCTL_ENH_MASK = 8'he0;
    localparam logic [7:0] URS_FRAC_ENH_MASK = 8'hff;

    // reset values
    localparam logic [7:0] URS_RST_DIVH    = 8'h00;
    localparam logic [7:0] URS_RST_DIVL    = 8'h01;
    localparam logic [7:0] URS_RST_FRAC    = 8'h00;
    localparam logic [7:0] URS_RST_HOLD    = 8'h00;
    localparam logic [7:0] URS_RST_IEN     = 8'h00;
    localparam logic [7:0] URS_RST_FCTL    = 8'h00;
    localparam logic [7:0] URS_RST_IST     = 8'h01;
    localparam logic [7:0] URS_IST_MODEM   = 8'h00;
    localparam logic [7:0] URS_RST_LCTL    = 8'h00;
    localparam logic [7:0] URS_RST_MCTL    = 8'h00;
    localparam logic [7:0] URS_RST_LSTS    = 8'h60;
    localparam logic [3:0] URS_RST_MSTS_LO = 4'h0;
    localparam logic [3:0] URS_RST_MSTS_WR = 4'h0;
    localparam logic [7:0] URS_RST_SCR     = 8'hff;
    localparam logic [7:0] URS_RST_EMODE   = 8'h00;
    localparam logic [7:0] URS_RST_LVL     = 8'h00;
    localparam logic [7:0] URS_RST_TRIG    = 8'h00;
    localparam logic [7:0] URS_RST_FEAT    = 8'h00;
    localparam logic [7:0] URS_RST_EFEAT   = 8'h00;
    localparam logic [7:0] URS_RST_FLOW    = 8'h00;

    // host bus pins and receive input
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] data;
        logic       rd_b;
        logic       wr_b;
        logic       cs_b;
        logic       rx;
    } urs_pins_t;
    localparam urs_pins_t URS_PINS_IDLE = '{addr: 3'h0, data: 8'h00, rd_b: 1'b1,
                                            wr_b: 1'b1, cs_b: 1'b1, rx: 1'b1};

    // modem inputs, ordered as the upper status nibble
    typedef struct packed {
        logic cd_b;
        logic ri_b;
        logic dsr_b;
        logic cts_b;
    } urs_modem_t;

    // synchroniser bundle: pins, modem, bus mode, power save, reset pin
    localparam int URS_SYNC_W = $bits(urs_pins_t) + $bits(urs_modem_t) + 3;
    localparam logic [URS_SYNC_W-1:0] URS_SYNC_IDLE = {URS_PINS_IDLE, 4'hf, 1'b1, 1'b0, 1'b0};

    // register selected by one access
    typedef enum logic [4:0] {
        URS_SEL_NONE, URS_SEL_RXH, URS_SEL_TXH, URS_SEL_DIVL, URS_SEL_DIVH,
        URS_SEL_FRAC, URS_SEL_IEN, URS_SEL_IST, URS_SEL_FCTL, URS_SEL_LCTL,
        URS_SEL_MCTL, URS_SEL_LSTS, URS_SEL_MSTS, URS_SEL_SCR, URS_SEL_LVL,
        URS_SEL_EMODE, URS_SEL_TRIG, URS_SEL_FEAT, URS_SEL_EFEAT, URS_SEL_RES1,
        URS_SEL_RES2, URS_SEL_PAU1, URS_SEL_PAU2
    } urs_sel_t;

endpackage : urs_pkg

/* File: core/urs_sync.sv */
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none

module urs_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_async,
    output logic [W-1:0]      o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } urs_sync_t;

    urs_sync_t st_ff;
    urs_sync_t nxt_st;

    // first stage feeds only the second
    always_comb begin
        nxt_st.meta = i_async;
        nxt_st.hold = st_ff.meta;
    end

    // both stages reset to the idle levels
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '{meta: RST_VAL, hold: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.hold;

endmodule : urs_sync

`default_nettype wire

/* File: core/urs_bank.sv */
// register bank with power-up and reset-pin defaults of a 16550-style serial port
`timescale 1ns/1ps
`default_nettype none

module urs_bank (
    input  wire logic                i_clock,
    input  wire logic                i_rst_b,
    input  wire logic                i_reset_pin,
    input  wire logic                i_bus_mode,
    input  wire logic                i_power_save,
    input  wire urs_pkg::urs_pins_t  i_pins,
    input  wire urs_pkg::urs_modem_t i_modem,
    output logic [7:0]               o_data,
    output logic                     o_data_oe,
    output logic                     o_tx,
    output logic                     o_rts_b,
    output logic                     o_dtr_b,
    output logic                     o_irq,
    output logic                     o_irq_oe
);
    import urs_pkg::*;

    typedef struct packed {
        logic [1:0][7:0] div_high;
        logic [1:0][7:0] div_low;
        logic [7:0]      frac;
        logic [7:0]      irq_en;
        logic [7:0]      fifo_ctl;
        logic [7:0]      line_ctl;
        logic [7:0]      modem_ctl;
        logic [7:0]      scratch;
        logic [7:0]      emode;
        logic [7:0]      trig;
        logic [7:0]      feat;
        logic [7:0]      efeat;
        logic [3:0][7:0] flow;
        logic [3:0]      mstat_delta;
        logic [3:0]      mstat_wr;
        urs_modem_t      modem_prev;
        logic            rd_prev;
        logic            wr_prev;
        logic [2:0]      addr_prev;
        logic [7:0]      data_prev;
        logic [7:0]      dout;
        logic            dout_oe;
        logic            tx;
        logic            rts_b;
        logic            dtr_b;
        logic            irq;
        logic            irq_oe;
    } urs_state_t;

    // power-up image; idle pin levels with the interrupt pin floating
    localparam urs_state_t PWR_UP = '{
        div_high:    '{URS_RST_DIVH, URS_RST_DIVH},
        div_low:     '{URS_RST_DIVL, URS_RST_DIVL},
        frac:        URS_RST_FRAC,
        irq_en:      URS_RST_IEN,
        fifo_ctl:    URS_RST_FCTL,
        line_ctl:    URS_RST_LCTL,
        modem_ctl:   URS_RST_MCTL,
        scratch:     URS_RST_SCR,
        emode:       URS_RST_EMODE,
        trig:        URS_RST_TRIG,
        feat:        URS_RST_FEAT,
        efeat:       URS_RST_EFEAT,
        flow:        '{default: URS_RST_FLOW},
        mstat_delta: URS_RST_MSTS_LO,
        mstat_wr:    URS_RST_MSTS_WR,
        modem_prev:  4'hf,
        addr_prev:   3'h0,
        data_prev:   8'h00,
        dout:        8'h00,
        tx:          1'b1,
        rts_b:       1'b1,
        dtr_b:       1'b1,
        irq:         1'b1,
        default:     1'b0
    };

    urs_state_t            st_ff;
    urs_state_t            nxt_st;
    logic [URS_SYNC_W-1:0] sync_in;
    logic [URS_SYNC_W-1:0] sync_out;
    urs_pins_t             pins_s;
    urs_pins_t             pins_g;
    urs_modem_t            modem_s;
    logic                  mode_s;
    logic                  ps_s;
    logic                  rpin_s;
    logic                  rd_act;
    logic                  wr_act;
    logic                  wr_commit;
    logic                  rd_done;
    logic                  pending;
    logic [3:0]            delta_set;

    // register address decode for one access
    function automatic urs_sel_t decode(input logic [2:0] a, input logic [7:0] lc,
                                        input logic swap, input logic wr);
        urs_sel_t s;
        s = URS_SEL_NONE;
        if (lc == URS_LCTL_ENH_KEY) begin
            unique case (a)
                URS_OFS_TRIG:  s = wr ? URS_SEL_TRIG : URS_SEL_LVL;
                URS_OFS_FEAT:  s = URS_SEL_FEAT;
                URS_OFS_EFEAT: s = URS_SEL_EFEAT;
                URS_OFS_LCTL:  s = URS_SEL_LCTL;
                URS_OFS_RES1:  s = URS_SEL_RES1;
                URS_OFS_RES2:  s = URS_SEL_RES2;
                URS_OFS_PAU1:  s = URS_SEL_PAU1;
                URS_OFS_PAU2:  s = URS_SEL_PAU2;
            endcase
        end else if (lc[URS_LCTL_DLAB] && (a == URS_OFS_DIVL)) begin
            s = URS_SEL_DIVL;
        end else if (lc[URS_LCTL_DLAB] && (a == URS_OFS_DIVH)) begin
            s = URS_SEL_DIVH;
        end else if (lc[URS_LCTL_DLAB] && (a == URS_OFS_FRAC)) begin
            s = URS_SEL_FRAC;
        end else begin
            unique case (a)
                URS_OFS_HOLD: s = wr ? URS_SEL_TXH : URS_SEL_RXH;
                URS_OFS_IEN:  s = URS_SEL_IEN;
                URS_OFS_IST:  s = wr ? URS_SEL_FCTL : URS_SEL_IST;
                URS_OFS_LCTL: s = URS_SEL_LCTL;
                URS_OFS_MCTL: s = URS_SEL_MCTL;
                URS_OFS_LSTS: s = URS_SEL_LSTS;
                URS_OFS_MSTS: s = URS_SEL_MSTS;
                URS_OFS_SCR:  s = swap ? (wr ? URS_SEL_EMODE : URS_SEL_LVL) : URS_SEL_SCR;
            endcase
        end
        return s;
    endfunction : decode

    // write that leaves enhanced-only bits frozen unless enabled
    function automatic logic [7:0] guard(input logic [7:0] old, input logic [7:0] din,
                                         input logic [7:0] mask, input logic en);
        return en ? din : ((old & mask) | (din & ~mask));
    endfunction : guard

    // pin inputs pass two flip-flops first
    assign sync_in = {i_pins, i_modem, i_bus_mode, i_power_save, i_reset_pin};

    urs_sync #(
        .W       (URS_SYNC_W),
        .RST_VAL (URS_SYNC_IDLE)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_async (sync_in),
        .o_sync  (sync_out)
    );

    assign {pins_s, modem_s, mode_s, ps_s, rpin_s} = sync_out;

    // power save isolates bus and receive; modem, mode, reset stay live
    assign pins_g = ps_s ? URS_PINS_IDLE : pins_s;

    // strobe mode uses both strobes, select mode uses the write pin as direction
    assign rd_act    = ~pins_g.cs_b & (mode_s ? ~pins_g.rd_b : pins_g.wr_b);
    assign wr_act    = ~pins_g.cs_b & ~pins_g.wr_b;
    assign wr_commit = st_ff.wr_prev & ~wr_act;
    assign rd_done   = st_ff.rd_prev & ~rd_act;
    assign pending   = (|st_ff.mstat_delta) & st_ff.irq_en[URS_IEN_MODEM];

    // modem change detectors
    assign delta_set[0] = st_ff.modem_prev.cts_b ^ modem_s.cts_b;
    assign delta_set[1] = st_ff.modem_prev.dsr_b ^ modem_s.dsr_b;
    assign delta_set[2] = ~st_ff.modem_prev.ri_b & modem_s.ri_b;
    assign delta_set[3] = st_ff.modem_prev.cd_b ^ modem_s.cd_b;

    // next state: bus access, status, reset pin, output pins
    always_comb begin
        logic en;
        logic rd_clr;
        logic nxt_pend;
        nxt_st = st_ff;
        en = st_ff.efeat[URS_EFEAT_ENH];
        rd_clr = 1'b0;
        nxt_pend = 1'b0;
        nxt_st.rd_prev = rd_act;
        nxt_st.wr_prev = wr_act;
        if (rd_act || wr_act) begin
            nxt_st.addr_prev = pins_g.addr;
            nxt_st.data_prev = pins_g.data;
        end
        // committed write at the end of the write strobe
        if (wr_commit) begin
            unique case (decode(st_ff.addr_prev, st_ff.line_ctl, st_ff.feat[URS_FEAT_SWAP], 1'b1))
                URS_SEL_DIVL:  nxt_st.div_low = {2{st_ff.data_prev}};
                URS_SEL_DIVH:  nxt_st.div_high = {2{st_ff.data_prev}};
                URS_SEL_FRAC:  nxt_st.frac = guard(st_ff.frac, st_ff.data_prev,
                                                   URS_FRAC_ENH_MASK, en);
                URS_SEL_IEN:   nxt_st.irq_en = guard(st_ff.irq_en, st_ff.data_prev,
                                                     URS_IEN_ENH_MASK, en);
                URS_SEL_FCTL:  nxt_st.fifo_ctl = guard(st_ff.fifo_ctl, st_ff.data_prev,
                                                       URS_FCTL_ENH_MASK, en);
                URS_SEL_LCTL:  nxt_st.line_ctl = st_ff.data_prev;
                URS_SEL_MCTL:  nxt_st.modem_ctl = guard(st_ff.modem_ctl, st_ff.data_prev,
                                                        URS_MCTL_ENH_MASK, en);
                URS_SEL_MSTS:  nxt_st.mstat_wr = st_ff.data_prev[7:4];
                URS_SEL_SCR:   nxt_st.scratch = st_ff.data_prev;
                URS_SEL_EMODE: nxt_st.emode = st_ff.data_prev;
                URS_SEL_TRIG:  nxt_st.trig = st_ff.data_prev;
                URS_SEL_FEAT:  nxt_st.feat = st_ff.data_prev;
                URS_SEL_EFEAT: nxt_st.efeat = st_ff.data_prev;
                URS_SEL_RES1:  nxt_st.flow[0] = st_ff.data_prev;
                URS_SEL_RES2:  nxt_st.flow[1] = st_ff.data_prev;
                URS_SEL_PAU1:  nxt_st.flow[2] = st_ff.data_prev;
                URS_SEL_PAU2:  nxt_st.flow[3] = st_ff.data_prev;
                default:       nxt_st.data_prev = st_ff.data_prev;
            endcase
        end
        // read data driven while the read strobe stands
        nxt_st.dout_oe = rd_act;
        nxt_st.dout = 8'h00;
        if (rd_act) begin
            unique case (decode(pins_g.addr, st_ff.line_ctl, st_ff.feat[URS_FEAT_SWAP], 1'b0))
                URS_SEL_DIVL:  nxt_st.dout = st_ff.div_low[0];
                URS_SEL_DIVH:  nxt_st.dout = st_ff.div_high[0];
                URS_SEL_FRAC:  nxt_st.dout = st_ff.frac;
                URS_SEL_RXH:   nxt_st.dout = URS_RST_HOLD;
                URS_SEL_IEN:   nxt_st.dout = st_ff.irq_en;
                URS_SEL_IST:   nxt_st.dout = pending ? URS_IST_MODEM : URS_RST_IST;
                URS_SEL_LCTL:  nxt_st.dout = st_ff.line_ctl;
                URS_SEL_MCTL:  nxt_st.dout = st_ff.modem_ctl;
                URS_SEL_LSTS:  nxt_st.dout = URS_RST_LSTS;
                URS_SEL_MSTS:  nxt_st.dout = {~modem_s, st_ff.mstat_delta};
                URS_SEL_SCR:   nxt_st.dout = st_ff.scratch;
                URS_SEL_LVL:   nxt_st.dout = URS_RST_LVL;
                URS_SEL_FEAT:  nxt_st.dout = st_ff.feat;
                URS_SEL_EFEAT: nxt_st.dout = st_ff.efeat;
                URS_SEL_RES1:  nxt_st.dout = st_ff.flow[0];
                URS_SEL_RES2:  nxt_st.dout = st_ff.flow[1];
                URS_SEL_PAU1:  nxt_st.dout = st_ff.flow[2];
                URS_SEL_PAU2:  nxt_st.dout = st_ff.flow[3];
                default:       nxt_st.dout = 8'h00;
            endcase
        end
        // modem deltas clear at the end of their read; a new change wins
        if (rd_done) begin
            rd_clr = decode(st_ff.addr_prev, st_ff.line_ctl, st_ff.feat[URS_FEAT_SWAP], 1'b0)
                     == URS_SEL_MSTS;
        end
        nxt_st.mstat_delta = (rd_clr ? 4'h0 : st_ff.mstat_delta) | delta_set;
        nxt_st.modem_prev = modem_s;
        // reset pin: everything to defaults except the divisor latches; the modem change detector reloads the live inputs
        if (rpin_s) begin
            nxt_st = PWR_UP;
            nxt_st.div_high = st_ff.div_high;
            nxt_st.div_low = st_ff.div_low;
            nxt_st.mstat_delta = URS_RST_MSTS_LO;
            nxt_st.mstat_wr = URS_RST_MSTS_WR;
            nxt_st.modem_prev = modem_s;
        end
        // output pins follow the next register image
        nxt_pend = (|nxt_st.mstat_delta) & nxt_st.irq_en[URS_IEN_MODEM];
        nxt_st.tx = ~nxt_st.line_ctl[URS_LCTL_BREAK];
        nxt_st.rts_b = ~nxt_st.modem_ctl[URS_MCTL_RTS];
        nxt_st.dtr_b = ~nxt_st.modem_ctl[URS_MCTL_DTR];
        if (mode_s) begin
            nxt_st.irq_oe = nxt_st.modem_ctl[URS_MCTL_OUT2];
            nxt_st.irq = nxt_pend;
        end else begin
            nxt_st.irq_oe = 1'b1;
            nxt_st.irq = ~nxt_pend;
        end
    end

    // power-up loads the full default image including the divisors
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= PWR_UP;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_data    = st_ff.dout;
    assign o_data_oe = st_ff.dout_oe;
    assign o_tx      = st_ff.tx;
    assign o_rts_b   = st_ff.rts_b;
    assign o_dtr_b   = st_ff.dtr_b;
    assign o_irq     = st_ff.irq;
    assign o_irq_oe  = st_ff.irq_oe;

    // reset pin held one cycle, then released
    sequence seq_pin_reset;
        rpin_s ##1 !rpin_s;
    endsequence

    // divisor latches hold power-up defaults at the first edge
    AST_PWRUP_DIV: assert property (@(posedge i_clock)
        $rose(i_rst_b) |-> (st_ff.div_high == PWR_UP.div_high)
                           && (st_ff.div_low == PWR_UP.div_low))
        else $error("divisors not at power-up defaults");

    // reset pin does not disturb the divisors
    AST_PIN_KEEPS_DIV: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        rpin_s ##1 rpin_s |=> (st_ff.div_low == $past(st_ff.div_low, 2))
                              && (st_ff.div_high == $past(st_ff.div_high, 2)))
        else $error("reset pin changed a divisor");

    // low status nibble is clear right after a reset pin
    AST_MSTS_LOW: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        seq_pin_reset |-> (st_ff.mstat_delta == URS_RST_MSTS_LO))
        else $error("modem status low nibble not clear after reset");

    // writable upper status bits cleared by the reset pin
    AST_MSTS_WR: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        rpin_s |=> (st_ff.mstat_wr == URS_RST_MSTS_WR))
        else $error("writable modem status bits survived reset");

    // no register write lands while in power save
    AST_PS_NO_WRITE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ps_s [*2] |-> !wr_commit && !rd_act ##1 !st_ff.dout_oe)
        else $error("bus access seen during power save");

    // receive input reads idle high during power save
    AST_PS_RX_IDLE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ps_s |-> pins_g.rx && pins_g.cs_b)
        else $error("receive input not isolated in power save");

    // output pins reach their reset levels when the pin releases
    AST_RST_PINS: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        seq_pin_reset |-> o_tx && o_rts_b && o_dtr_b
                          && (mode_s ? !o_irq_oe : (o_irq_oe && o_irq)))
        else $error("output pins wrong after reset pin");

endmodule : urs_bank

`default_nettype wire

/* File: sim/urs_host.sv */
// host processor model driving the parallel register bus
`timescale 1ns/1ps
`default_nettype none

module urs_host
    import urs_pkg::*;
(
    input  wire logic         i_clock,
    input  wire logic         i_bus_mode,
    input  wire logic [7:0]   i_data,
    output var urs_pkg::urs_pins_t o_pins
);
    // bus parked idle, receive line held at its idle high level
    initial begin
        o_pins = URS_PINS_IDLE;
    end

    // write: strobe low 3 cycles, released data line inverted, 4 idle cycles
    task automatic write(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_pins <= '{addr: a, data: d, rd_b: 1'b1, wr_b: 1'b0, cs_b: 1'b0, rx: 1'b1};
        repeat (3) @(posedge i_clock);
        o_pins <= '{addr: a, data: ~d, rd_b: 1'b1, wr_b: 1'b1, cs_b: 1'b1, rx: 1'b1};
        repeat (4) @(posedge i_clock);
    endtask : write

    // read: strobe mode uses the read strobe, chip-select mode a high write pin
    task automatic read(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_pins <= '{addr: a, data: ~o_pins.data, rd_b: ~i_bus_mode, wr_b: 1'b1, cs_b: 1'b0,
                    rx: 1'b1};
        repeat (4) @(posedge i_clock);
        d = i_data;
        o_pins <= '{addr: a, data: o_pins.data, rd_b: 1'b1, wr_b: 1'b1, cs_b: 1'b1,
                    rx: 1'b1};
        repeat (4) @(posedge i_clock);
    endtask : read
endmodule : urs_host
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the reset-state register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import urs_pkg::*;
    logic        i_clock;
    logic        i_rst_b;
    logic        i_reset_pin;
    logic        i_bus_mode;
    logic        i_power_save;
    urs_pins_t   pins;
    urs_modem_t  modem;
    logic [7:0]  o_data;
    logic        o_data_oe;
    logic        o_tx;
    logic        o_rts_b;
    logic        o_dtr_b;
    logic        o_irq;
    logic        o_irq_oe;
    int          num_errors;
    int          n_checks;

    urs_bank uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reset_pin(i_reset_pin),
        .i_bus_mode(i_bus_mode), .i_power_save(i_power_save), .i_pins(pins),
        .i_modem(modem), .o_data(o_data), .o_data_oe(o_data_oe), .o_tx(o_tx),
        .o_rts_b(o_rts_b), .o_dtr_b(o_dtr_b), .o_irq(o_irq), .o_irq_oe(o_irq_oe));
    // read data is only seen on the bus while the block drives it
    urs_host u_host (.i_clock(i_clock), .i_bus_mode(i_bus_mode),
        .i_data(o_data_oe ? o_data : 8'hzz), .o_pins(pins));

    // 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read(a, d);
        chk(d, exp);
    endtask : rd_chk

    // pins as {tx, rts_b, dtr_b, irq_oe, irq}; data_oe checked low, data bus released when idle
    task automatic pins_chk(input logic [4:0] exp);
        chk({2'h0, o_data_oe, o_tx, o_rts_b, o_dtr_b, o_irq_oe, o_irq}, {3'h0, exp});
    endtask : pins_chk

    task automatic pulse_reset_pin();
        @(posedge i_clock);
        i_reset_pin <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_reset_pin <= 1'b0;
        repeat (4) @(posedge i_clock);
    endtask : pulse_reset_pin

    task automatic set_ps(input logic v);
        @(posedge i_clock);
        i_power_save <= v;
        repeat (4) @(posedge i_clock);
    endtask : set_ps

    // one clear-to-send pulse on the modem inputs, back to idle
    task automatic modem_blip();
        @(posedge i_clock);
        modem <= 4'he;
        repeat (4) @(posedge i_clock);
        modem <= 4'hf;
        repeat (4) @(posedge i_clock);
    endtask : modem_blip

    // every bank read back against its default, divisors as given
    task automatic check_defaults(input logic [7:0] divl, input logic [7:0] divh);
        rd_chk(URS_OFS_LCTL, 8'h00);
        rd_chk(URS_OFS_IEN, 8'h00);
        rd_chk(URS_OFS_IST, 8'h01);
        rd_chk(URS_OFS_MCTL, 8'h00);
        rd_chk(URS_OFS_LSTS, 8'h60);
        rd_chk(URS_OFS_MSTS, 8'h00);
        rd_chk(URS_OFS_SCR, 8'hff);
        u_host.write(URS_OFS_LCTL, 8'h80);
        rd_chk(URS_OFS_DIVL, divl);
        rd_chk(URS_OFS_DIVH, divh);
        rd_chk(URS_OFS_FRAC, 8'h00);
        u_host.write(URS_OFS_LCTL, URS_LCTL_ENH_KEY);
        for (int i = 0; i < 8; i++) begin
            if (i != 3) rd_chk(3'(i), 8'h00);
        end
        u_host.write(URS_OFS_LCTL, 8'h00);
    endtask : check_defaults

    // hang guard, far beyond the roughly 650 cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clock);
        num_errors++;
        report_and_stop();
    end

    // main sequence
    initial begin
        num_errors = 0;
        n_checks = 0;
        i_rst_b = 1'b0;
        i_reset_pin = 1'b0;
        i_bus_mode = 1'b1;
        i_power_save = 1'b0;
        modem = 4'hf;
        repeat (12) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clock);
        pins_chk(5'b11100);
        check_defaults(8'h01, 8'h00);
        $display("test power_up done");
        // load non-default values everywhere but fifo control, trigger and emode, break and modem outputs active
        u_host.write(URS_OFS_IEN, 8'h0f);
        u_host.write(URS_OFS_MCTL, 8'h0b);
        u_host.write(URS_OFS_SCR, 8'h3c);
        u_host.write(URS_OFS_MSTS, 8'hf0);
        u_host.write(URS_OFS_LCTL, 8'h80);
        u_host.write(URS_OFS_DIVL, 8'h5a);
        u_host.write(URS_OFS_DIVH, 8'ha5);
        u_host.write(URS_OFS_LCTL, URS_LCTL_ENH_KEY);
        u_host.write(URS_OFS_EFEAT, 8'h10);
        u_host.write(URS_OFS_FEAT, 8'h30);
        for (int i = 4; i < 8; i++) begin
            u_host.write(3'(i), 8'(i * 17));
        end
        u_host.write(URS_OFS_LCTL, 8'h80);
        u_host.write(URS_OFS_FRAC, 8'h07);
        u_host.write(URS_OFS_LCTL, 8'h40);
        // modem change leaves a pending modem interrupt for the reset to clear
        modem_blip();
        rd_chk(URS_OFS_SCR, 8'h3c);
        rd_chk(URS_OFS_IST, 8'h00);
        pins_chk(5'b00011);
        pulse_reset_pin();
        pins_chk(5'b11100);
        check_defaults(8'h5a, 8'ha5);
        $display("test reset_pin done");
        // bus isolated in power save, reset pin still honoured
        u_host.write(URS_OFS_SCR, 8'h12);
        set_ps(1'b1);
        u_host.write(URS_OFS_SCR, 8'h55);
        modem_blip();
        set_ps(1'b0);
        rd_chk(URS_OFS_SCR, 8'h12);
        rd_chk(URS_OFS_MSTS, 8'h01);
        set_ps(1'b1);
        pulse_reset_pin();
        set_ps(1'b0);
        rd_chk(URS_OFS_SCR, 8'hff);
        $display("test power_save done");
        // chip-select bus mode: interrupt line driven high after reset
        @(posedge i_clock);
        i_bus_mode <= 1'b0;
        repeat (4) @(posedge i_clock);
        pins_chk(5'b11111);
        u_host.write(URS_OFS_MCTL, 8'h03);
        rd_chk(URS_OFS_MCTL, 8'h03);
        pins_chk(5'b10011);
        pulse_reset_pin();
        pins_chk(5'b11111);
        $display("test chip_select_mode done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
